// ---- hdl/cfd_config_decode.v ----
// cfd_config_decode.v: configuration word store and decode
// assumes: programmer writes words by index over a simple strobe port
// in program mode; pins arrive asynchronous and are synchronised here.
//
// Summary of operation
// - pll prescale code selects oscillator divider
// - regulator bit enables usb regulator
// - two-bit field picks brown-out trip level
// - two-bit field picks brown-out mode
// - power-up timer enable is active low
// - watchdog postscale is two to the n
// - blocks 0..5 writable only when bit set
// - boot and eeprom write protect bits
// - config writes rejected when protect bit clear
// - cross-block table reads denied when guarded
// - boot size locked once block protected
// - low-voltage entry allowed while bit set
// - bit clear frees select pin for i/o
// - bit clear: only high-voltage entry accepted
// - high-voltage entry always honoured
// - low-voltage mode keeps select pin reserved
`timescale 1ns/1ps
`include "cfd_map.vh"
module cfd_config_decode #(
	parameter NUM_BLOCKS = 6
) (
	input  wire        clock_i,              // core clock, 200 MHz
	input  wire        rst_n_i,              // async reset, active low
	input  wire        high_prog_level_i,    // high programming level on reset pin
	input  wire        program_select_pin_i, // program-mode select pin level
	input  wire        cfg_wr_i,             // config word write strobe
	input  wire [3:0]  cfg_idx_i,            // config word index
	input  wire [7:0]  cfg_wdata_i,          // config write data
	input  wire [3:0]  cfg_ridx_i,           // config read index
	output reg  [7:0]  cfg_rdata_o,          // config read data
	output reg         cfg_wr_err_o,         // write refused, one-cycle pulse
	input  wire        mem_wr_i,             // memory write request
	input  wire [2:0]  mem_wr_blk_i,         // 0..5 block, 6 boot, 7 eeprom
	output reg         mem_wr_ok_o,          // write granted, one-cycle pulse
	output reg         mem_wr_deny_o,        // write blocked, one-cycle pulse
	input  wire        tbl_rd_i,             // table read request
	input  wire [2:0]  tbl_tgt_blk_i,        // target block, 6 boot
	input  wire [2:0]  tbl_src_blk_i,        // executing block, 6 boot
	output reg         tbl_rd_ok_o,          // table read granted pulse
	output reg         tbl_rd_deny_o,        // table read denied pulse
	input  wire        sw_brownout_i,        // software brown-out control
	input  wire        sleep_i,              // core in sleep
	output reg  [2:0]  pll_input_prescale_o, // raw prescale code
	output reg  [3:0]  pll_divide_o,         // divider ratio 1..12
	output reg         usb_regulator_enable_o, // usb regulator on
	output reg  [1:0]  brownout_level_select_o, // 3=2.0V 2=2.7V 1=4.2V 0=4.5V
	output reg         brownout_enable_o,    // brown-out reset active
	output reg         powerup_timer_run_o,  // power-up timer in use
	output reg  [3:0]  watchdog_postscale_select_o, // postscale code n
	output reg  [15:0] watchdog_postscale_ratio_o,  // 2^n minus one
	output reg         lv_mode_o,            // low-voltage program mode
	output reg         hv_mode_o,            // high-voltage program mode
	output reg         select_pin_gpio_o     // select pin free as gpio
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire hv_sync;
	wire pgm_sync;
	cfd_sync2 #(.RST_VAL(1'b0)) u_sync_hv (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.d_i     (high_prog_level_i),
		.q_o     (hv_sync)
	);
	cfd_sync2 #(.RST_VAL(1'b0)) u_sync_pgm (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.d_i     (program_select_pin_i),
		.q_o     (pgm_sync)
	);

	// ----------------------------------------------------------------
	// configuration words
	// ----------------------------------------------------------------
	reg [7:0] clock_prescale_config_q;
	reg [7:0] brownout_power_config_q;
	reg [7:0] watchdog_config_q;
	reg [7:0] debug_program_config_q;
	reg [7:0] code_protect_low_q;
	reg [7:0] code_protect_high_q;
	reg [7:0] block_write_protect_low_q;
	reg [7:0] special_write_protect_q;
	reg [7:0] table_read_protect_low_q;
	reg [7:0] table_read_protect_high_q;

	wire low_voltage_program_enable = debug_program_config_q[`CFD_LVP_BIT];
	wire config_write_protect = special_write_protect_q[`CFD_CONFIG_WP_BIT];
	wire boot_write_protect   = special_write_protect_q[`CFD_BOOT_WP_BIT];
	wire eeprom_write_protect = special_write_protect_q[`CFD_EEPROM_WP_BIT];
	wire boot_code_protect    = code_protect_high_q[`CFD_BOOT_CP_BIT];
	wire boot_read_guard      = table_read_protect_high_q[`CFD_BOOT_RG_BIT];

	// protect bits are active low; any zero among boot/block0 locks size
	wire boot_block_size_lock = ~boot_code_protect | ~code_protect_low_q[0] |
		~boot_write_protect | ~block_write_protect_low_q[0] |
		~boot_read_guard | ~table_read_protect_low_q[0];

	// ----------------------------------------------------------------
	// program mode entry
	// ----------------------------------------------------------------
	reg  lv_mode_q;
	reg  hv_mode_q;
	wire hv_mode_d = hv_sync;
	// low-voltage entry needs the bit set and yields to high voltage
	wire lv_mode_d = ~hv_sync & pgm_sync & low_voltage_program_enable;
	wire prog_mode = hv_mode_q | lv_mode_q;

	// the enable bit itself may change only under high-voltage entry
	wire cfg_wr_legal = cfg_wr_i & prog_mode & config_write_protect;

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hv_mode_q <= 1'b0;
			lv_mode_q <= 1'b0;
		end else begin
			hv_mode_q <= hv_mode_d;
			lv_mode_q <= lv_mode_d;
		end
	end

	// ----------------------------------------------------------------
	// config word writes
	// ----------------------------------------------------------------
	reg [7:0] dbg_wdata;
	always @* begin
		dbg_wdata = cfg_wdata_i;
		if (boot_block_size_lock)
			dbg_wdata[`CFD_BOOT_BLOCK_SIZE_MSB:`CFD_BOOT_BLOCK_SIZE_LSB] =
				debug_program_config_q[`CFD_BOOT_BLOCK_SIZE_MSB:`CFD_BOOT_BLOCK_SIZE_LSB];
		if (!hv_mode_q)
			dbg_wdata[`CFD_LVP_BIT] = low_voltage_program_enable;
	end

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clock_prescale_config_q   <= `CFD_RST_CLOCK_PRESCALE;
			brownout_power_config_q   <= `CFD_RST_BROWNOUT_POWER;
			watchdog_config_q         <= `CFD_RST_WATCHDOG;
			debug_program_config_q    <= `CFD_RST_DEBUG_PROGRAM;
			code_protect_low_q        <= `CFD_RST_CODE_PROTECT_LO;
			code_protect_high_q       <= `CFD_RST_CODE_PROTECT_HI;
			block_write_protect_low_q <= `CFD_RST_BLOCK_WP_LOW;
			special_write_protect_q   <= `CFD_RST_SPECIAL_WP;
			table_read_protect_low_q  <= `CFD_RST_TABLE_RG_LOW;
			table_read_protect_high_q <= `CFD_RST_TABLE_RG_HIGH;
			cfg_wr_err_o              <= 1'b0;
		end else begin
			cfg_wr_err_o <= cfg_wr_i & ~cfg_wr_legal;
			if (cfg_wr_legal) begin
				case (cfg_idx_i)
					`CFD_IDX_CLOCK_PRESCALE: clock_prescale_config_q <= cfg_wdata_i & 8'h3F;
					`CFD_IDX_BROWNOUT_POWER: brownout_power_config_q <= cfg_wdata_i & 8'h3F;
					`CFD_IDX_WATCHDOG:       watchdog_config_q <= cfg_wdata_i & 8'h1F;
					`CFD_IDX_DEBUG_PROGRAM:  debug_program_config_q <= dbg_wdata;
					`CFD_IDX_CODE_PROTECT_LO: code_protect_low_q <= cfg_wdata_i & 8'h3F;
					`CFD_IDX_CODE_PROTECT_HI: code_protect_high_q <= cfg_wdata_i & 8'hC0;
					`CFD_IDX_BLOCK_WP_LOW:   block_write_protect_low_q <= cfg_wdata_i & 8'h3F;
					`CFD_IDX_SPECIAL_WP:     special_write_protect_q <= cfg_wdata_i & 8'hE0;
					`CFD_IDX_TABLE_RG_LOW:   table_read_protect_low_q <= cfg_wdata_i & 8'h3F;
					`CFD_IDX_TABLE_RG_HIGH:  table_read_protect_high_q <= cfg_wdata_i & 8'h40;
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// config readback (unmapped and unimplemented read zero)
	// ----------------------------------------------------------------
	reg [7:0] rd_mux;
	always @* begin
		case (cfg_ridx_i)
			`CFD_IDX_CLOCK_PRESCALE:  rd_mux = clock_prescale_config_q;
			`CFD_IDX_BROWNOUT_POWER:  rd_mux = brownout_power_config_q;
			`CFD_IDX_WATCHDOG:        rd_mux = watchdog_config_q;
			`CFD_IDX_DEBUG_PROGRAM:   rd_mux = debug_program_config_q;
			`CFD_IDX_CODE_PROTECT_LO: rd_mux = code_protect_low_q;
			`CFD_IDX_CODE_PROTECT_HI: rd_mux = code_protect_high_q;
			`CFD_IDX_BLOCK_WP_LOW:    rd_mux = block_write_protect_low_q;
			`CFD_IDX_SPECIAL_WP:      rd_mux = special_write_protect_q;
			`CFD_IDX_TABLE_RG_LOW:    rd_mux = table_read_protect_low_q;
			`CFD_IDX_TABLE_RG_HIGH:   rd_mux = table_read_protect_high_q;
			default:                  rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// memory write protection
	// ----------------------------------------------------------------
	reg mem_wr_allow;
	always @* begin
		case (mem_wr_blk_i)
			3'h6:    mem_wr_allow = boot_write_protect;
			3'h7:    mem_wr_allow = eeprom_write_protect;
			default: mem_wr_allow = (mem_wr_blk_i < NUM_BLOCKS) &
				block_write_protect_low_q[mem_wr_blk_i];
		endcase
	end

	// ----------------------------------------------------------------
	// table read protection
	// ----------------------------------------------------------------
	reg tbl_guard_open;
	always @* begin
		if (tbl_tgt_blk_i == 3'h6)
			tbl_guard_open = boot_read_guard;
		else if (tbl_tgt_blk_i < NUM_BLOCKS)
			tbl_guard_open = table_read_protect_low_q[tbl_tgt_blk_i];
		else
			tbl_guard_open = 1'b0;
	end
	// reads from inside the same block are never guarded
	wire tbl_allow = (tbl_tgt_blk_i == tbl_src_blk_i) | tbl_guard_open;

	// ----------------------------------------------------------------
	// decode of settings
	// ----------------------------------------------------------------
	wire [2:0] prescale = clock_prescale_config_q[`CFD_PRESCALE_MSB:`CFD_PRESCALE_LSB];
	reg  [3:0] divide_d;
	always @* begin
		case (prescale)
			3'h0:    divide_d = 4'h1;
			3'h1:    divide_d = 4'h2;
			3'h2:    divide_d = 4'h3;
			3'h3:    divide_d = 4'h4;
			3'h4:    divide_d = 4'h5;
			3'h5:    divide_d = 4'h6;
			3'h6:    divide_d = 4'hA;
			default: divide_d = 4'hC;
		endcase
	end

	wire [1:0] bor_mode = brownout_power_config_q[`CFD_BOR_MODE_LSB+1:`CFD_BOR_MODE_LSB];
	reg  bor_en_d;
	always @* begin
		case (bor_mode)
			`CFD_BOR_HW_ALWAYS:   bor_en_d = 1'b1;
			`CFD_BOR_HW_NO_SLEEP: bor_en_d = ~sleep_i;
			`CFD_BOR_SOFTWARE:    bor_en_d = sw_brownout_i;
			default:              bor_en_d = 1'b0;
		endcase
	end

	wire [3:0] wdps = watchdog_config_q[`CFD_WDPS_LSB+3:`CFD_WDPS_LSB];
	// ratio kept as 2^n - 1 so 1:32768 fits in sixteen bits
	wire [15:0] wd_ratio_d = (16'h0001 << wdps) - 16'h0001;

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_rdata_o                 <= 8'h00;
			mem_wr_ok_o                 <= 1'b0;
			mem_wr_deny_o               <= 1'b0;
			tbl_rd_ok_o                 <= 1'b0;
			tbl_rd_deny_o               <= 1'b0;
			pll_input_prescale_o        <= 3'h0;
			pll_divide_o                <= 4'h1;
			usb_regulator_enable_o      <= 1'b0;
			brownout_level_select_o     <= 2'h0;
			brownout_enable_o           <= 1'b0;
			powerup_timer_run_o         <= 1'b0;
			watchdog_postscale_select_o <= 4'h0;
			watchdog_postscale_ratio_o  <= 16'h0000;
			lv_mode_o                   <= 1'b0;
			hv_mode_o                   <= 1'b0;
			select_pin_gpio_o           <= 1'b0;
		end else begin
			cfg_rdata_o                 <= rd_mux;
			mem_wr_ok_o                 <= mem_wr_i & mem_wr_allow;
			mem_wr_deny_o               <= mem_wr_i & ~mem_wr_allow;
			tbl_rd_ok_o                 <= tbl_rd_i & tbl_allow;
			tbl_rd_deny_o               <= tbl_rd_i & ~tbl_allow;
			pll_input_prescale_o        <= prescale;
			pll_divide_o                <= divide_d;
			usb_regulator_enable_o      <= brownout_power_config_q[`CFD_VREG_BIT];
			brownout_level_select_o     <=
				brownout_power_config_q[`CFD_BOR_LEVEL_LSB+1:`CFD_BOR_LEVEL_LSB];
			brownout_enable_o           <= bor_en_d;
			powerup_timer_run_o         <= ~brownout_power_config_q[`CFD_POWERUP_TIMER_N_BIT];
			watchdog_postscale_select_o <= wdps;
			watchdog_postscale_ratio_o  <= wd_ratio_d;
			lv_mode_o                   <= lv_mode_q;
			hv_mode_o                   <= hv_mode_q;
			// pin is gpio only with the bit clear and not in low-voltage mode
			select_pin_gpio_o <= ~low_voltage_program_enable & ~lv_mode_q;
		end
	end
endmodule // cfd_config_decode

// ---- hdl/cfd_map.vh ----
// cfd_map.vh: configuration word indices, field positions, reset values
// assumes: included by the configuration decode design files only
`ifndef CFD_MAP_VH
`define CFD_MAP_VH

// ----------------------------------------------------------------
// configuration word indices (low byte of 300000h space)
// ----------------------------------------------------------------
`define CFD_IDX_CLOCK_PRESCALE   4'h0
`define CFD_IDX_BROWNOUT_POWER   4'h2
`define CFD_IDX_WATCHDOG         4'h3
`define CFD_IDX_DEBUG_PROGRAM    4'h6
`define CFD_IDX_CODE_PROTECT_LO  4'h8
`define CFD_IDX_CODE_PROTECT_HI  4'h9
`define CFD_IDX_BLOCK_WP_LOW     4'hA
`define CFD_IDX_SPECIAL_WP       4'hB
`define CFD_IDX_TABLE_RG_LOW     4'hC
`define CFD_IDX_TABLE_RG_HIGH    4'hD

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFD_PRESCALE_MSB         2
`define CFD_PRESCALE_LSB         0
`define CFD_POWERUP_TIMER_N_BIT           0
`define CFD_BOR_MODE_LSB         1
`define CFD_BOR_LEVEL_LSB        3
`define CFD_VREG_BIT             5
`define CFD_WDPS_LSB             1
`define CFD_LVP_BIT              2
`define CFD_BOOT_BLOCK_SIZE_MSB            5
`define CFD_BOOT_BLOCK_SIZE_LSB            4
`define CFD_BOOT_CP_BIT          6
`define CFD_EEPROM_WP_BIT        7
`define CFD_BOOT_WP_BIT          6
`define CFD_CONFIG_WP_BIT        5
`define CFD_BOOT_RG_BIT          6

// ----------------------------------------------------------------
// unprogrammed (reset) values
// ----------------------------------------------------------------
`define CFD_RST_CLOCK_PRESCALE   8'h00
`define CFD_RST_BROWNOUT_POWER   8'h1F
`define CFD_RST_WATCHDOG         8'h1F
`define CFD_RST_DEBUG_PROGRAM    8'h85
`define CFD_RST_CODE_PROTECT_LO  8'h3F
`define CFD_RST_CODE_PROTECT_HI  8'hC0
`define CFD_RST_BLOCK_WP_LOW     8'h3F
`define CFD_RST_SPECIAL_WP       8'hE0
`define CFD_RST_TABLE_RG_LOW     8'h3F
`define CFD_RST_TABLE_RG_HIGH    8'h40

// ----------------------------------------------------------------
// brown-out modes
// ----------------------------------------------------------------
`define CFD_BOR_OFF              2'h0
`define CFD_BOR_SOFTWARE         2'h1
`define CFD_BOR_HW_NO_SLEEP      2'h2
`define CFD_BOR_HW_ALWAYS        2'h3

`endif

// ---- hdl/cfd_sync2.v ----
// cfd_sync2.v: two-stage synchroniser for asynchronous pin levels
// assumes: one clock, async active-low reset
`timescale 1ns/1ps
module cfd_sync2 #(
	parameter RST_VAL = 1'b0
) (
	input  wire clock_i, // core clock
	input  wire rst_n_i, // async reset, active low
	input  wire d_i,     // asynchronous level
	output wire q_o      // synchronised level
);
	reg meta_q;
	reg sync_q;
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end
	assign q_o = sync_q;
endmodule // cfd_sync2

// ---- verification/cfd_config_decode_asserts.sv ----
// cfd_config_decode_asserts.sv: port-level checker for the config decoder
// assumes: bound to cfd_config_decode, one clock, async active-low reset
`timescale 1ns/1ps
module cfd_config_decode_asserts (
	input wire        clock_i,                     // core clock
	input wire        rst_n_i,                     // async reset, active low
	input wire        cfg_wr_i,                    // config write strobe
	input wire        cfg_wr_err_o,                // write refused pulse
	input wire        mem_wr_i,                    // memory write request
	input wire        mem_wr_ok_o,                 // write granted
	input wire        mem_wr_deny_o,               // write blocked
	input wire        tbl_rd_i,                    // table read request
	input wire [2:0]  tbl_tgt_blk_i,               // target block
	input wire [2:0]  tbl_src_blk_i,               // executing block
	input wire        tbl_rd_ok_o,                 // table read granted
	input wire        tbl_rd_deny_o,               // table read denied
	input wire [2:0]  pll_input_prescale_o,        // raw prescale code
	input wire [3:0]  pll_divide_o,                // divider ratio
	input wire [3:0]  watchdog_postscale_select_o, // postscale code
	input wire [15:0] watchdog_postscale_ratio_o,  // 2^n minus one
	input wire        lv_mode_o,                   // low-voltage mode
	input wire        hv_mode_o,                   // high-voltage mode
	input wire        select_pin_gpio_o            // select pin free
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_PRESCALE_DIV: assert property (pll_divide_o == ((pll_input_prescale_o == 3'h6) ? 4'hA :
		(pll_input_prescale_o == 3'h7) ? 4'hC : {1'b0, pll_input_prescale_o} + 4'h1))
		else $error("divider does not match prescale code");
	AST_WDT_RATIO: assert property (watchdog_postscale_ratio_o ==
		(16'h0001 << watchdog_postscale_select_o) - 16'h0001)
		else $error("postscale ratio does not match code");
	AST_MEM_ANSWER: assert property (mem_wr_i |=> (mem_wr_ok_o != mem_wr_deny_o))
		else $error("memory write not answered once");
	AST_MEM_IDLE: assert property (!mem_wr_i |=> !mem_wr_ok_o && !mem_wr_deny_o)
		else $error("memory write answer without request");
	AST_TBL_SAME: assert property (tbl_rd_i && tbl_tgt_blk_i == tbl_src_blk_i |=> tbl_rd_ok_o && !tbl_rd_deny_o)
		else $error("table read inside own block denied");
	AST_TBL_IDLE: assert property (!tbl_rd_i |=> !tbl_rd_ok_o && !tbl_rd_deny_o)
		else $error("table read answer without request");
	AST_HV_WINS: assert property (hv_mode_o |-> !lv_mode_o)
		else $error("low-voltage mode beside high-voltage mode");
	AST_LV_PIN_HELD: assert property (lv_mode_o |-> !select_pin_gpio_o)
		else $error("select pin freed in low-voltage mode");
	AST_NO_MODE_ERR: assert property (cfg_wr_i ##1 (!hv_mode_o && !lv_mode_o) |-> cfg_wr_err_o)
		else $error("config write outside program mode not refused");
	AST_ERR_CAUSE: assert property (!cfg_wr_i |=> !cfg_wr_err_o)
		else $error("write refusal without write");
endmodule // cfd_config_decode_asserts

bind cfd_config_decode cfd_config_decode_asserts u_chk (
	.clock_i, .rst_n_i, .cfg_wr_i, .cfg_wr_err_o, .mem_wr_i, .mem_wr_ok_o, .mem_wr_deny_o,
	.tbl_rd_i, .tbl_tgt_blk_i, .tbl_src_blk_i, .tbl_rd_ok_o, .tbl_rd_deny_o,
	.pll_input_prescale_o, .pll_divide_o, .watchdog_postscale_select_o,
	.watchdog_postscale_ratio_o, .lv_mode_o, .hv_mode_o, .select_pin_gpio_o
);

// ---- verification/cfd_prog_model.sv ----
// cfd_prog_model.sv: device programmer model driving pins and config writes
// assumes: same clock as the decoder; tasks are called by the testbench
`timescale 1ns/1ps
module cfd_prog_model (
	input  wire        clock_i,      // core clock
	output logic       high_prog_o,  // high programming level on reset pin
	output logic       select_pin_o, // program-mode select pin
	output logic       wr_o,         // config write strobe
	output logic [3:0] idx_o,        // config word index
	output logic [7:0] wdata_o       // config write data
);
	localparam logic [23:0] IMG_CONFIG_BASE = 24'h300000;
	localparam logic [23:0] IMG_EEPROM_BASE = 24'hF00000;

	initial begin
		high_prog_o = 1'b0;
		select_pin_o = 1'b0;
		wr_o = 1'b0;
		idx_o = 4'hF;
		wdata_o = 8'h00;
	end

	// lvp word is only rewritten by callers while this level is up
	task automatic set_hv(input logic v);
		@(posedge clock_i);
		high_prog_o <= v;
	endtask

	task automatic set_pin(input logic v);
		@(posedge clock_i);
		select_pin_o <= v;
	endtask

	// image address picks the word; released bus shows inverted data
	task automatic write_word(input logic [23:0] addr, input logic [7:0] data);
		logic [23:0] off;
		off = addr - IMG_CONFIG_BASE;
		@(posedge clock_i);
		wr_o <= 1'b1;
		idx_o <= off[3:0];
		wdata_o <= data;
		@(posedge clock_i);
		wr_o <= 1'b0;
		idx_o <= ~off[3:0];
		wdata_o <= ~data;
	endtask
endmodule // cfd_prog_model

// ---- verification/cfd_config_decode_tb.sv ----
// cfd_config_decode_tb.sv: self-checking bench for the config decoder
// assumes: programmer model drives pins and writes; bench drives the rest
`timescale 1ns/1ps
module cfd_config_decode_tb;
	logic clock_i, rst_n_i, mem_wr_i, tbl_rd_i, sw_brownout_i, sleep_i;
	logic [3:0] cfg_ridx_i;
	logic [2:0] mem_wr_blk_i, tbl_tgt_blk_i, tbl_src_blk_i;
	wire high_prog_level_i, program_select_pin_i, cfg_wr_i, cfg_wr_err_o;
	wire mem_wr_ok_o, mem_wr_deny_o, tbl_rd_ok_o, tbl_rd_deny_o, usb_regulator_enable_o;
	wire brownout_enable_o, powerup_timer_run_o, lv_mode_o, hv_mode_o, select_pin_gpio_o;
	wire [3:0] cfg_idx_i, pll_divide_o, watchdog_postscale_select_o;
	wire [7:0] cfg_wdata_i, cfg_rdata_o;
	wire [2:0] pll_input_prescale_o;
	wire [1:0] brownout_level_select_o;
	wire [15:0] watchdog_postscale_ratio_o;
	int err_count, compares, cyc, m;
	logic [7:0] rst_tab [14] = '{8'h00, 8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00, 8'h85,
		8'h00, 8'h3F, 8'hC0, 8'h3F, 8'hE0, 8'h3F, 8'h40};
	logic [3:0] div_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
	logic e;

	cfd_prog_model prog (.clock_i, .high_prog_o(high_prog_level_i),
		.select_pin_o(program_select_pin_i), .wr_o(cfg_wr_i), .idx_o(cfg_idx_i),
		.wdata_o(cfg_wdata_i));
	cfd_config_decode #(.NUM_BLOCKS(6)) DUT (.clock_i, .rst_n_i, .high_prog_level_i,
		.program_select_pin_i, .cfg_wr_i, .cfg_idx_i, .cfg_wdata_i, .cfg_ridx_i, .cfg_rdata_o,
		.cfg_wr_err_o, .mem_wr_i, .mem_wr_blk_i, .mem_wr_ok_o, .mem_wr_deny_o, .tbl_rd_i,
		.tbl_tgt_blk_i, .tbl_src_blk_i, .tbl_rd_ok_o, .tbl_rd_deny_o, .sw_brownout_i, .sleep_i,
		.pll_input_prescale_o, .pll_divide_o, .usb_regulator_enable_o, .brownout_level_select_o,
		.brownout_enable_o, .powerup_timer_run_o, .watchdog_postscale_select_o,
		.watchdog_postscale_ratio_o, .lv_mode_o, .hv_mode_o, .select_pin_gpio_o);

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic er);
		prog.write_word(24'h300000 + {20'h0, i}, d);
		#1;
		chk("cfg_wr_err_o", {15'h0, er}, {15'h0, cfg_wr_err_o});
		@(posedge clock_i);
		#1;
	endtask
	task automatic rd(input logic [3:0] i, input logic [7:0] ex);
		@(posedge clock_i);
		cfg_ridx_i <= i;
		@(posedge clock_i);
		#1;
		chk("cfg_rdata_o", {8'h0, ex}, {8'h0, cfg_rdata_o});
	endtask
	task automatic modes(input logic h, input logic p);
		prog.set_hv(h);
		prog.set_pin(p);
		repeat (6) @(posedge clock_i);
		#1;
	endtask
	// t=1 table read, t=0 memory write; answers a cycle later
	task automatic req(input logic t, input logic [2:0] b, input logic [2:0] s, input logic ex);
		@(posedge clock_i);
		mem_wr_i <= ~t;
		tbl_rd_i <= t;
		mem_wr_blk_i <= b;
		tbl_tgt_blk_i <= b;
		tbl_src_blk_i <= s;
		@(posedge clock_i);
		mem_wr_i <= 1'b0;
		tbl_rd_i <= 1'b0;
		#1;
		chk("grant_deny", {14'h0, ex, ~ex}, t ? {14'h0, tbl_rd_ok_o, tbl_rd_deny_o} :
			{14'h0, mem_wr_ok_o, mem_wr_deny_o});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			stop_test;
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n_i, mem_wr_i, tbl_rd_i, sw_brownout_i, sleep_i} = 5'h00;
		{cfg_ridx_i, mem_wr_blk_i, tbl_tgt_blk_i, tbl_src_blk_i} = 13'h0000;
		{err_count, compares, cyc} = 0;
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		for (int k = 0; k < 14; k++) rd(k[3:0], rst_tab[k]);
		chk("powerup_timer_run_o", 16'h0, {15'h0, powerup_timer_run_o});
		chk("brownout_enable_o", 16'h1, {15'h0, brownout_enable_o});
		chk("watchdog_postscale_ratio_o", 16'h7FFF, watchdog_postscale_ratio_o);
		wr(4'h0, 8'h03, 1'b1);
		modes(1'b0, 1'b1);
		chk("lv_mode_o", 16'h1, {15'h0, lv_mode_o});
		chk("select_pin_gpio_o", 16'h0, {15'h0, select_pin_gpio_o});
		modes(1'b1, 1'b1);
		chk("hv_lv", 16'h2, {14'h0, hv_mode_o, lv_mode_o});
		modes(1'b1, 1'b0);
		for (int c = 0; c < 8; c++) begin
			wr(4'h0, c[7:0], 1'b0);
			chk("pll_divide_o", {12'h0, div_tab[c]}, {12'h0, pll_divide_o});
		end
		for (m = 0; m < 16; m++) begin
			@(posedge clock_i);
			sleep_i <= m[2];
			sw_brownout_i <= m[3];
			wr(4'h2, {2'b00, m[0], m[1:0], m[1:0], m[1]}, 1'b0);
			e = (m[1:0] == 2'h3) | (m[1:0] == 2'h2 & ~m[2]) | (m[1:0] == 2'h1 & m[3]);
			chk("brownout_enable_o", {15'h0, e}, {15'h0, brownout_enable_o});
			chk("brownout_level_select_o", m[1:0], {14'h0, brownout_level_select_o});
			chk("usb_regulator_enable_o", m[0], {15'h0, usb_regulator_enable_o});
			chk("powerup_timer_run_o", {15'h0, ~m[1]}, {15'h0, powerup_timer_run_o});
		end
		for (int n = 0; n < 16; n++) begin
			wr(4'h3, {3'b000, n[3:0], 1'b1}, 1'b0);
			chk("watchdog_postscale_ratio_o", (16'h1 << n) - 16'h1, watchdog_postscale_ratio_o);
		end
		wr(4'h6, 8'hB5, 1'b0);
		rd(4'h6, 8'hB5);
		wr(4'hA, 8'h14, 1'b0);
		wr(4'hB, 8'hA0, 1'b0);
		wr(4'hC, 8'h2A, 1'b0);
		wr(4'hD, 8'h00, 1'b0);
		for (int b = 0; b < 8; b++) req(1'b0, b[2:0], 3'h0, 8'h94 >> b);
		for (int t = 0; t < 7; t++) req(1'b1, t[2:0], (t + 1) % 7, 8'h2A >> t);
		req(1'b1, 3'h0, 3'h0, 1'b1);
		wr(4'h6, 8'h85, 1'b0);
		rd(4'h6, 8'hB5);
		wr(4'h6, 8'h81, 1'b0);
		rd(4'h6, 8'hB1);
		modes(1'b0, 1'b1);
		chk("lv_mode_o", 16'h0, {15'h0, lv_mode_o});
		chk("select_pin_gpio_o", 16'h1, {15'h0, select_pin_gpio_o});
		modes(1'b1, 1'b0);
		chk("hv_mode_o", 16'h1, {15'h0, hv_mode_o});
		wr(4'hB, 8'h80, 1'b0);
		wr(4'h0, 8'h05, 1'b1);
		rd(4'h0, 8'h07);
		stop_test;
	end
endmodule // cfd_config_decode_tb
